// ---- include/sdc_pkg.sv ----
package sdc_pkg;

  // Sync delay field and latency
  localparam int unsigned DLY_W = 12;
  localparam int unsigned DLY_LO_W = 8;
  localparam int unsigned DLY_HI_W = 4;
  localparam int unsigned DEPTH = 4096;
  localparam int unsigned LAT_FIXED = 10;
  localparam logic [DLY_W-1:0] DLY_RST = 12'h000;
  localparam logic [DLY_W-1:0] FILL_MAX = 12'hFFF;

  // Sync lanes per channel: bit 0 hsync, bit 1 vsync
  localparam int unsigned SYNC_W = 2;
  localparam int unsigned NUM_CH = 2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_MODE = 8'h10;
  localparam logic [7:0] IDX_LINK_SEL = 8'h18;
  localparam logic [7:0] IDX_DLY_A_LO = 8'h28;
  localparam logic [7:0] IDX_DLY_A_HI = 8'h29;
  localparam logic [7:0] IDX_DLY_B_LO = 8'h2A;
  localparam logic [7:0] IDX_DLY_B_HI = 8'h2B;
  localparam logic [7:0] IDX_STATUS = 8'h3F;

  // Address decode
  localparam int unsigned ADDR_IDX_LSB = 2;
  localparam int unsigned ADDR_IDX_MSB = 9;
  localparam int unsigned ADDR_MSB = 31;
  localparam int unsigned HTRANS_ACT_BIT = 1;

  // Field positions
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned MODE_MSB = 6;
  localparam int unsigned LINK_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_TWO_BIT = 1;
  localparam logic [1:0] MODE_TWO_STREAM = 2'b10;
  localparam logic [1:0] MODE_RST = 2'b00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;

  // Configuration word crossing to the pixel domain
  localparam int unsigned CFG_W = 2 * DLY_W + 3;
  localparam int unsigned CFG_A_LSB = 0;
  localparam int unsigned CFG_B_LSB = DLY_W;
  localparam int unsigned CFG_MODE_LSB = 2 * DLY_W;
  localparam int unsigned CFG_LINK_BIT = 2 * DLY_W + 2;

  typedef enum logic [1:0] {
    CDC_IDLE = 2'b01,
    CDC_BUSY = 2'b10
  } sdc_cdc_state_t;

endpackage : sdc_pkg

// ---- logic/sdc_cfg_cdc.sv ----
module sdc_cfg_cdc (
  // Source domain
  input wire logic clk_src,
  input wire logic rst_src_n,
  input wire logic [sdc_pkg::CFG_W-1:0] cfg_src,
  output logic busy,
  // Destination domain
  input wire logic clk_dst,
  input wire logic rst_dst_n,
  output logic [sdc_pkg::CFG_W-1:0] cfg_dst
);

  typedef struct packed {
    sdc_pkg::sdc_cdc_state_t state;
    logic req_tgl;
    logic [2:0] ack_s;
    logic [sdc_pkg::CFG_W-1:0] data;
  } sdc_src_t;

  typedef struct packed {
    logic [2:0] req_s;
    logic ack_tgl;
    logic [sdc_pkg::CFG_W-1:0] data;
  } sdc_dst_t;

  sdc_src_t src_r;
  sdc_src_t src_nxt;
  sdc_dst_t dst_r;
  sdc_dst_t dst_nxt;

  always_comb begin
    src_nxt = src_r;
    src_nxt.ack_s = {src_r.ack_s[1:0], dst_r.ack_tgl};
    case (src_r.state)
      sdc_pkg::CDC_IDLE: begin
        if (cfg_src != src_r.data) begin
          src_nxt.data = cfg_src;
          src_nxt.req_tgl = ~src_r.req_tgl;
          src_nxt.state = sdc_pkg::CDC_BUSY;
        end
      end
      sdc_pkg::CDC_BUSY: begin
        // Data held still until the far side has echoed the toggle
        if (src_r.ack_s[1] == src_r.ack_s[2] && src_r.ack_s[2] == src_r.req_tgl) begin
          src_nxt.state = sdc_pkg::CDC_IDLE;
        end
      end
      default: src_nxt.state = sdc_pkg::CDC_IDLE;
    endcase
  end

  always_ff @(posedge clk_src or negedge rst_src_n) begin
    if (!rst_src_n) begin
      src_r <= '{state: sdc_pkg::CDC_IDLE, req_tgl: 1'b0, ack_s: 3'h0, data: '0};
    end else begin
      src_r <= src_nxt;
    end
  end

  always_comb begin
    dst_nxt = dst_r;
    dst_nxt.req_s = {dst_r.req_s[1:0], src_r.req_tgl};
    if (dst_r.req_s[1] == dst_r.req_s[2] && dst_r.req_s[2] != dst_r.ack_tgl) begin
      dst_nxt.data = src_r.data;
      dst_nxt.ack_tgl = dst_r.req_s[2];
    end
  end

  always_ff @(posedge clk_dst or negedge rst_dst_n) begin
    if (!rst_dst_n) begin
      dst_r <= '{req_s: 3'h0, ack_tgl: 1'b0, data: '0};
    end else begin
      dst_r <= dst_nxt;
    end
  end

  // A change still waiting to launch counts as busy, so no idle gap shows between two crossings
  assign busy = (src_r.state == sdc_pkg::CDC_BUSY) || (cfg_src != src_r.data);
  assign cfg_dst = dst_r.data;

endmodule : sdc_cfg_cdc

// ---- logic/sdc_sync_delay_config.sv ----
module sdc_sync_delay_config (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Pixel clock
  input wire logic clk_pix,
  // Syncs from the video input
  input wire logic hsync_a_in,
  input wire logic vsync_a_in,
  input wire logic hsync_b_in,
  input wire logic vsync_b_in,
  // Syncs towards the LVDS output
  output logic hsync_a_out,
  output logic vsync_a_out,
  output logic hsync_b_out,
  output logic vsync_b_out
);

  typedef struct packed {
    logic [sdc_pkg::DLY_W-1:0] dly_a;
    logic [sdc_pkg::DLY_W-1:0] dly_b;
    logic [1:0] chan_mode;
    logic link_sel;
    logic ap_wr;
    logic [7:0] ap_idx;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } sdc_regs_t;

  logic [1:0] rst_sys_r;
  logic [1:0] rst_pix_r;
  logic rst_sys_n;
  logic rst_pix_n;
  sdc_regs_t regs_r;
  sdc_regs_t regs_nxt;
  logic cfg_busy;
  logic [sdc_pkg::CFG_W-1:0] cfg_sys;
  logic [sdc_pkg::CFG_W-1:0] cfg_pix;
  logic [sdc_pkg::DLY_W-1:0] pix_dly_a;
  logic [sdc_pkg::DLY_W-1:0] pix_dly_b;
  logic pix_two_stream;
  logic [sdc_pkg::NUM_CH-1:0][sdc_pkg::SYNC_W-1:0] sync_in_ch;
  logic [sdc_pkg::NUM_CH-1:0][sdc_pkg::SYNC_W-1:0] sync_out_ch;
  logic [sdc_pkg::NUM_CH-1:0][sdc_pkg::DLY_W-1:0] dly_ch;

  // Reset release, one synchroniser per domain
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sys_r <= 2'h0;
    end else begin
      rst_sys_r <= {rst_sys_r[0], 1'b1};
    end
  end

  always_ff @(posedge clk_pix or negedge nrst) begin
    if (!nrst) begin
      rst_pix_r <= 2'h0;
    end else begin
      rst_pix_r <= {rst_pix_r[0], 1'b1};
    end
  end

  assign rst_sys_n = rst_sys_r[1];
  assign rst_pix_n = rst_pix_r[1];

  // Register file; writes land in the data phase, reads are
  // prepared in the address phase from the post-write values so
  // that a read right behind a write sees the new contents.
  always_comb begin
    logic [7:0] wd;
    logic [7:0] idx;
    logic hit;
    wd = hwdata[7:0];
    idx = haddr[sdc_pkg::ADDR_IDX_MSB:sdc_pkg::ADDR_IDX_LSB];
    hit = (haddr[sdc_pkg::ADDR_MSB:sdc_pkg::ADDR_IDX_MSB+1] == '0);
    regs_nxt = regs_r;
    regs_nxt.ap_wr = 1'b0;
    regs_nxt.hreadyout = 1'b1;
    regs_nxt.hresp = sdc_pkg::HRESP_OKAY;
    if (regs_r.ap_wr) begin
      if (regs_r.ap_idx == sdc_pkg::IDX_DLY_A_LO) begin
        regs_nxt.dly_a[sdc_pkg::DLY_LO_W-1:0] = wd;
      end else if (regs_r.ap_idx == sdc_pkg::IDX_DLY_A_HI) begin
        regs_nxt.dly_a[sdc_pkg::DLY_W-1:sdc_pkg::DLY_LO_W] = wd[sdc_pkg::DLY_HI_W-1:0];
      end else if (regs_r.ap_idx == sdc_pkg::IDX_DLY_B_LO) begin
        regs_nxt.dly_b[sdc_pkg::DLY_LO_W-1:0] = wd;
      end else if (regs_r.ap_idx == sdc_pkg::IDX_DLY_B_HI) begin
        regs_nxt.dly_b[sdc_pkg::DLY_W-1:sdc_pkg::DLY_LO_W] = wd[sdc_pkg::DLY_HI_W-1:0];
      end else if (regs_r.ap_idx == sdc_pkg::IDX_CHAN_MODE) begin
        regs_nxt.chan_mode = wd[sdc_pkg::MODE_MSB:sdc_pkg::MODE_LSB];
      end else if (regs_r.ap_idx == sdc_pkg::IDX_LINK_SEL) begin
        regs_nxt.link_sel = wd[sdc_pkg::LINK_BIT];
      end
    end
    if (hsel && hready && htrans[sdc_pkg::HTRANS_ACT_BIT]) begin
      regs_nxt.ap_wr = hwrite && hit;
      regs_nxt.ap_idx = idx;
      regs_nxt.hrdata = sdc_pkg::WORD_ZERO;
      if (!hwrite && hit) begin
        if (idx == sdc_pkg::IDX_DLY_A_LO) begin
          regs_nxt.hrdata[sdc_pkg::DLY_LO_W-1:0] = regs_nxt.dly_a[sdc_pkg::DLY_LO_W-1:0];
        end else if (idx == sdc_pkg::IDX_DLY_A_HI) begin
          regs_nxt.hrdata[sdc_pkg::DLY_HI_W-1:0] =
            regs_nxt.dly_a[sdc_pkg::DLY_W-1:sdc_pkg::DLY_LO_W];
        end else if (idx == sdc_pkg::IDX_DLY_B_LO) begin
          regs_nxt.hrdata[sdc_pkg::DLY_LO_W-1:0] = regs_nxt.dly_b[sdc_pkg::DLY_LO_W-1:0];
        end else if (idx == sdc_pkg::IDX_DLY_B_HI) begin
          regs_nxt.hrdata[sdc_pkg::DLY_HI_W-1:0] =
            regs_nxt.dly_b[sdc_pkg::DLY_W-1:sdc_pkg::DLY_LO_W];
        end else if (idx == sdc_pkg::IDX_CHAN_MODE) begin
          regs_nxt.hrdata[sdc_pkg::MODE_MSB:sdc_pkg::MODE_LSB] = regs_nxt.chan_mode;
        end else if (idx == sdc_pkg::IDX_LINK_SEL) begin
          regs_nxt.hrdata[sdc_pkg::LINK_BIT] = regs_nxt.link_sel;
        end else if (idx == sdc_pkg::IDX_STATUS) begin
          regs_nxt.hrdata[sdc_pkg::STAT_BUSY_BIT] = cfg_busy;
          regs_nxt.hrdata[sdc_pkg::STAT_TWO_BIT] = !regs_nxt.link_sel &&
            (regs_nxt.chan_mode == sdc_pkg::MODE_TWO_STREAM);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      regs_r <= '{dly_a: sdc_pkg::DLY_RST, dly_b: sdc_pkg::DLY_RST,
                  chan_mode: sdc_pkg::MODE_RST, link_sel: 1'b0, ap_wr: 1'b0,
                  ap_idx: 8'h00, hreadyout: 1'b1, hresp: sdc_pkg::HRESP_OKAY,
                  hrdata: sdc_pkg::WORD_ZERO};
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign hreadyout = regs_r.hreadyout;
  assign hrdata = regs_r.hrdata;
  assign hresp = regs_r.hresp;

  // Settings cross as one word so mode and delays always switch together
  assign cfg_sys = {regs_r.link_sel, regs_r.chan_mode, regs_r.dly_b, regs_r.dly_a};

  sdc_cfg_cdc u_cfg_cdc (
    .clk_src(clk_sys),
    .rst_src_n(rst_sys_n),
    .cfg_src(cfg_sys),
    .busy(cfg_busy),
    .clk_dst(clk_pix),
    .rst_dst_n(rst_pix_n),
    .cfg_dst(cfg_pix)
  );

  assign pix_dly_a = cfg_pix[sdc_pkg::CFG_A_LSB +: sdc_pkg::DLY_W];
  assign pix_dly_b = cfg_pix[sdc_pkg::CFG_B_LSB +: sdc_pkg::DLY_W];
  assign pix_two_stream = !cfg_pix[sdc_pkg::CFG_LINK_BIT] &&
    (cfg_pix[sdc_pkg::CFG_MODE_LSB +: 2] == sdc_pkg::MODE_TWO_STREAM);

  // Outside two-stream mode both channels follow the channel A delay
  assign dly_ch[0] = pix_dly_a;
  assign dly_ch[1] = pix_two_stream ? pix_dly_b : pix_dly_a;
  assign sync_in_ch[0] = {vsync_a_in, hsync_a_in};
  assign sync_in_ch[1] = {vsync_b_in, hsync_b_in};

  // Changing a delay mid-frame can drop or repeat the sync edges between the old and new delay
  for (genvar ch = 0; ch < sdc_pkg::NUM_CH; ch++) begin : g_line
    sdc_sync_line u_line (
      .clk_pix(clk_pix),
      .rst_pix_n(rst_pix_n),
      .sync_in(sync_in_ch[ch]),
      .delay(dly_ch[ch]),
      .sync_out(sync_out_ch[ch])
    );
  end

  assign hsync_a_out = sync_out_ch[0][0];
  assign vsync_a_out = sync_out_ch[0][1];
  assign hsync_b_out = sync_out_ch[1][0];
  assign vsync_b_out = sync_out_ch[1][1];

endmodule : sdc_sync_delay_config

// ---- logic/sdc_sync_line.sv ----
module sdc_sync_line (
  // Pixel clock
  input wire logic clk_pix,
  input wire logic rst_pix_n,
  // Syncs and programmed delay
  input wire logic [sdc_pkg::SYNC_W-1:0] sync_in,
  input wire logic [sdc_pkg::DLY_W-1:0] delay,
  output logic [sdc_pkg::SYNC_W-1:0] sync_out
);

  typedef struct packed {
    logic [sdc_pkg::DLY_W-1:0] wp;
    logic [sdc_pkg::DLY_W-1:0] fill;
    logic [sdc_pkg::SYNC_W-1:0] rd;
    logic [sdc_pkg::LAT_FIXED-1:0][sdc_pkg::SYNC_W-1:0] pipe;
  } sdc_line_t;

  logic [sdc_pkg::SYNC_W-1:0] hist [0:sdc_pkg::DEPTH-1];
  sdc_line_t line_r;
  sdc_line_t line_nxt;

  always_comb begin
    line_nxt = line_r;
    line_nxt.wp = line_r.wp + 1'b1;
    if (line_r.fill != sdc_pkg::FILL_MAX) begin
      line_nxt.fill = line_r.fill + 1'b1;
    end
    // Unwritten history reads as idle unless the delay is zero; a zero delay wraps the whole buffer
    if (line_r.fill < delay) begin
      line_nxt.rd = '0;
    end else begin
      line_nxt.rd = hist[line_r.wp - delay];
    end
    line_nxt.pipe = {line_r.pipe[sdc_pkg::LAT_FIXED-2:0], line_r.rd};
  end

  always_ff @(posedge clk_pix) begin
    hist[line_r.wp] <= sync_in;
  end

  always_ff @(posedge clk_pix or negedge rst_pix_n) begin
    if (!rst_pix_n) begin
      line_r <= '0;
    end else begin
      line_r <= line_nxt;
    end
  end

  assign sync_out = line_r.pipe[sdc_pkg::LAT_FIXED-1];

endmodule : sdc_sync_line

// ---- test/sdc_chk_props.sv ----
module sdc_chk (
  // Bus
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Pixel side
  input wire logic clk_pix,
  input wire logic hsync_a_out,
  input wire logic vsync_a_out,
  input wire logic hsync_b_out,
  input wire logic vsync_b_out
);
  logic pend_r;
  logic [7:0] idx_r;
  logic [3:0][7:0] sh_r;
  logic [3:0] pc_r;
  wire logic acc = hsel && hready && htrans[1] && haddr[31:10] == 22'h00_0000;

  // Shadow of the four delay bytes, as written
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'b0;
      idx_r <= 8'h00;
      sh_r <= '0;
    end else begin
      pend_r <= acc && hwrite;
      if (acc) begin
        idx_r <= haddr[9:2];
      end
      if (pend_r && idx_r[7:2] == 6'h0A) begin
        sh_r[idx_r[1:0]] <= hwdata[7:0];
      end
    end
  end

  // Saturating count of pixel clocks since reset release
  always_ff @(posedge clk_pix or negedge nrst) begin
    if (!nrst) begin
      pc_r <= 4'h0;
    end else if (pc_r != 4'hF) begin
      pc_r <= pc_r + 4'h1;
    end
  end

  sequence rd_s(logic [7:0] i);
    acc && !hwrite && haddr[9:2] == i;
  endsequence

  rsv_upper_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    hrdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  lo_a_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_s(sdc_pkg::IDX_DLY_A_LO) |=> hrdata[7:0] == sh_r[0])
    else $error("delay A low byte mismatch");
  hi_a_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_s(sdc_pkg::IDX_DLY_A_HI) |=> hrdata[7:0] == {4'h0, sh_r[1][3:0]})
    else $error("delay A high nibble mismatch");
  lo_b_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_s(sdc_pkg::IDX_DLY_B_LO) |=> hrdata[7:0] == sh_r[2])
    else $error("delay B low byte mismatch");
  hi_b_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_s(sdc_pkg::IDX_DLY_B_HI) |=> hrdata[7:0] == {4'h0, sh_r[3][3:0]})
    else $error("delay B high nibble mismatch");
  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc && !hwrite && haddr[9:2] inside {[8'h2C:8'h3E]} |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ready_okay_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    hreadyout && hresp == sdc_pkg::HRESP_OKAY) else $error("bus wait or error");
  early_quiet_a: assert property (@(posedge clk_pix) disable iff (!nrst)
    pc_r < 4'hB |-> !(hsync_a_out || vsync_a_out || hsync_b_out || vsync_b_out))
    else $error("sync out sooner than pipeline allows");
endmodule : sdc_chk

bind sdc_sync_delay_config sdc_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .clk_pix(clk_pix), .hsync_a_out(hsync_a_out),
  .vsync_a_out(vsync_a_out), .hsync_b_out(hsync_b_out), .vsync_b_out(vsync_b_out)
);

// ---- test/sdc_video_host.sv ----
module sdc_video_host (
  // Pixel clock
  input wire logic clk_pix,
  // Syncs towards the bridge
  output logic hsync_a,
  output logic vsync_a,
  output logic hsync_b,
  output logic vsync_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsync_a = 1'b0;
    vsync_a = 1'b0;
    hsync_b = 1'b0;
    vsync_b = 1'b0;
  end

  // One-clock pulse on both lanes; returns at the edge that samples it
  task automatic pulse(input logic ch_b);
    @(posedge clk_pix);
    hsync_a <= !ch_b;
    vsync_a <= !ch_b;
    hsync_b <= ch_b;
    vsync_b <= ch_b;
    @(posedge clk_pix);
    hsync_a <= 1'b0;
    vsync_a <= 1'b0;
    hsync_b <= 1'b0;
    vsync_b <= 1'b0;
  endtask : pulse
endmodule : sdc_video_host

// ---- test/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic clk_pix;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [3:0] si;
  logic [3:0] so;
  logic [31:0] rv;
  int num_errors;
  int tests_run;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_pix = 1'b0;
    #3;
    forever #62.5 clk_pix = ~clk_pix;
  end

  sdc_video_host host (.clk_pix(clk_pix), .hsync_a(si[0]), .vsync_a(si[1]),
    .hsync_b(si[2]), .vsync_b(si[3]));

  sdc_sync_delay_config DUT (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clk_pix(clk_pix),
    .hsync_a_in(si[0]), .vsync_a_in(si[1]), .hsync_b_in(si[2]), .vsync_b_in(si[3]),
    .hsync_a_out(so[0]), .vsync_a_out(so[1]), .hsync_b_out(so[2]), .vsync_b_out(so[3]));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Ready is looked at on the rising edge, before the slave's flops move
  task automatic wait_rdy();
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) return;
    end
    check("bus ready", 32'h0000_0000, 32'h0000_0001);
    test_done();
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h00_0000, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rv = hrdata;
    hsel <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    check("register read", rv, exp);
  endtask : rd

  // Wait until the new settings have reached the pixel side
  task automatic settle();
    for (int n = 0; n < 40; n++) begin
      xfer(1'b0, sdc_pkg::IDX_STATUS, 32'h0000_0000);
      if (rv[sdc_pkg::STAT_BUSY_BIT] === 1'b0) return;
    end
    check("crossing busy", 32'h0000_0001, 32'h0000_0000);
    test_done();
  endtask : settle

  // Pixel clocks from the sampling edge of a pulse to its echo
  task automatic meas(input logic ch_b, input int exp);
    int n;
    // Drain older pulses, which a changed delay could replay
    repeat (300) @(posedge clk_pix);
    host.pulse(ch_b);
    n = 0;
    #1;
    while (so[{ch_b, 1'b0}] !== 1'b1 && n < 5000) begin
      @(posedge clk_pix);
      n++;
      #1;
    end
    check("sync delay", n, exp);
    check("vsync lane", {31'h0000_0000, so[{ch_b, 1'b1}]}, 32'h0000_0001);
    if (n >= 5000) test_done();
  endtask : meas

  initial begin
    num_errors = 0;
    tests_run = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    repeat (3) @(posedge clk_pix);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      rd(sdc_pkg::IDX_DLY_A_LO + 8'(i), 32'h0000_0000);
    end
    rd(sdc_pkg::IDX_CHAN_MODE, 32'h0000_0000);
    rd(sdc_pkg::IDX_LINK_SEL, 32'h0000_0000);
    $display("Test reset values done");
    xfer(1'b1, sdc_pkg::IDX_DLY_A_LO, 32'h5A5A_5A20);
    xfer(1'b1, sdc_pkg::IDX_DLY_A_HI, 32'h0000_00F1);
    rd(sdc_pkg::IDX_DLY_A_LO, 32'h0000_0020);
    rd(sdc_pkg::IDX_DLY_A_HI, 32'h0000_0001);
    xfer(1'b1, sdc_pkg::IDX_DLY_B_LO, 32'h0000_0028);
    xfer(1'b1, sdc_pkg::IDX_DLY_B_HI, 32'h0000_00F0);
    rd(sdc_pkg::IDX_DLY_B_LO, 32'h0000_0028);
    rd(sdc_pkg::IDX_DLY_B_HI, 32'h0000_0000);
    xfer(1'b1, 8'h30, 32'h0000_00FF);
    rd(8'h30, 32'h0000_0000);
    $display("Test register access done");
    settle();
    meas(1'b0, 298);
    xfer(1'b1, sdc_pkg::IDX_CHAN_MODE, 32'h0000_0040);
    settle();
    meas(1'b1, 50);
    rd(sdc_pkg::IDX_STATUS, 32'h0000_0002);
    xfer(1'b1, sdc_pkg::IDX_LINK_SEL, 32'h0000_0010);
    settle();
    rd(sdc_pkg::IDX_STATUS, 32'h0000_0000);
    meas(1'b1, 298);
    xfer(1'b1, sdc_pkg::IDX_LINK_SEL, 32'h0000_0000);
    xfer(1'b1, sdc_pkg::IDX_CHAN_MODE, 32'h0000_0020);
    settle();
    meas(1'b1, 298);
    $display("Test sync delay done");
    test_done();
  end
endmodule : tb_top
